// ===== hdl/cfe_core.sv
`timescale 1ns/100ps
module cfe_core
  import cfe_pkg::*;
(
  input wire logic mclk_i,                        // core clock, four per instruction
  input wire logic arst_n_i,                      // asynchronous reset, active low
  input wire logic master_reset_pin_en_i,                     // pin configured as master reset
  input wire logic master_reset_pin_n_i,          // master reset pin, active low
  input wire logic pullup_req_i,                  // pull-up asked for by software
  output logic pullup_en_o,                       // weak pull-up enable of that pin
  output logic [CFE_PROG_AW-1:0] prog_addr_o,     // program flash address
  input wire logic [CFE_INSN_W-1:0] prog_data_i,  // program flash word
  output logic [CFE_FILE_AW-1:0] data_addr_o,     // register file address
  output logic data_re_o,                         // register file read strobe
  input wire logic [CFE_DATA_W-1:0] data_rdata_i, // read data, cycle after strobe
  output logic data_we_o,                         // register file write strobe
  output logic [CFE_DATA_W-1:0] data_wdata_o,     // register file write data
  output logic [CFE_DATA_W-1:0] acc_o,            // accumulator
  output logic [CFE_DATA_W-1:0] status_o          // status register
);

  cfe_state_t s_q;
  cfe_state_t s_d;
  logic mrst;
  logic [1:0] grp;
  logic [5:0] op;
  logic [4:0] faddr;
  logic int_f;
  logic rd_f;
  logic [7:0] opnd;
  logic [7:0] lit;
  logic [7:0] bmask;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [8:0] pc_m1;
  logic [7:0] r;
  logic [2:0] nf;
  logic [2:0] fm;
  logic wr_f;
  logic wr_w;
  logic skip;
  logic jump;
  logic [7:0] st_base;

  // synchronous master reset through the pin, only when configured
  assign mrst = master_reset_pin_en_i & ~master_reset_pin_n_i;

  // instruction fields and file address, indirect through the select register
  assign grp = s_q.ir[11:10];
  assign op = s_q.ir[11:6];
  assign lit = s_q.ir[7:0];
  assign faddr = (s_q.ir[4:0] == CFE_ADDR_INDIRECT) ? s_q.fsel : s_q.ir[4:0];
  assign int_f = (faddr == CFE_ADDR_INDIRECT) || (faddr == CFE_ADDR_PCLOW)
    || (faddr == CFE_ADDR_STATUS) || (faddr == CFE_ADDR_FSEL);
  assign rd_f = (grp == GRP_BIT) || ((grp == GRP_FILE) && (s_q.ir[9:7] != 3'h0));
  assign pc_m1 = s_q.pc - 9'h001;
  assign bmask = 8'h01 << s_q.ir[7:CFE_IR_BIT_LO];

  // operand mux: own registers answer inside, the rest from the file; the
  // accumulator has no address at all, so software cannot alias it
  always_comb
  begin
    if (faddr == CFE_ADDR_PCLOW)
    begin
      opnd = pc_m1[7:0];
    end
    else if (faddr == CFE_ADDR_STATUS)
    begin
      opnd = {s_q.st[7:CFE_ST_HI+1], 1'b0, s_q.st[CFE_ST_HI-1:0]};
    end
    else if (faddr == CFE_ADDR_FSEL)
    begin
      opnd = {CFE_FSEL_HI, s_q.fsel};
    end
    else if (faddr == CFE_ADDR_INDIRECT)
    begin
      opnd = 8'h00;
    end
    else
    begin
      opnd = data_rdata_i;
    end
  end

  // 8-bit ALU; operand is only meaningful in phase three
  always_comb
  begin
    r = s_q.w;
    nf = s_q.st[2:0];
    fm = 3'h0;
    wr_f = 1'b0;
    wr_w = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    sum = {1'b0, opnd} + {1'b0, s_q.w};
    nib = {1'b0, opnd[3:0]} + {1'b0, s_q.w[3:0]};
    if (op == OP_SUB)
    begin
      sum = {1'b0, opnd} + {1'b0, ~s_q.w} + 9'h001;
      nib = {1'b0, opnd[3:0]} + {1'b0, ~s_q.w[3:0]} + 5'h01;
    end
    case (grp)
      GRP_FILE:
      begin
        wr_f = s_q.ir[CFE_IR_DEST];
        wr_w = ~s_q.ir[CFE_IR_DEST];
        fm = 3'b100;
        case (op)
          OP_MOVWF:
          begin
            r = s_q.w;
            wr_w = 1'b0;
            fm = 3'h0;
          end
          OP_CLR: r = 8'h00;
          OP_SUB, OP_ADD:
          begin
            r = sum[7:0];
            nf[CFE_ST_CARRY] = sum[8];
            nf[1] = nib[4];
            fm = 3'b111;
          end
          OP_DEC: r = opnd - 8'h01;
          OP_IOR: r = opnd | s_q.w;
          OP_AND: r = opnd & s_q.w;
          OP_XOR: r = opnd ^ s_q.w;
          OP_MOV: r = opnd;
          OP_COM: r = ~opnd;
          OP_INC: r = opnd + 8'h01;
          OP_DECSZ, OP_INCSZ:
          begin
            r = (op == OP_DECSZ) ? opnd - 8'h01 : opnd + 8'h01;
            skip = (r == 8'h00);
            fm = 3'h0;
          end
          OP_RR, OP_RL:
          begin
            r = (op == OP_RR) ? {s_q.st[CFE_ST_CARRY], opnd[7:1]}
              : {opnd[6:0], s_q.st[CFE_ST_CARRY]};
            nf[CFE_ST_CARRY] = (op == OP_RR) ? opnd[0] : opnd[7];
            fm = 3'b001;
          end
          default:
          begin
            r = {opnd[CFE_IR_NIB:0], opnd[7:CFE_IR_NIB+1]};
            fm = 3'h0;
          end
        endcase
        // misc group (no-op and peripheral controls) has no effect in this core
        if ((op == OP_MOVWF) && !s_q.ir[CFE_IR_DEST])
        begin
          wr_f = 1'b0;
        end
      end
      GRP_BIT:
      begin
        case (s_q.ir[9:8])
          SUB_0: r = opnd & ~bmask;
          SUB_1: r = opnd | bmask;
          SUB_2: skip = ((opnd & bmask) == 8'h00);
          default: skip = ((opnd & bmask) != 8'h00);
        endcase
        wr_f = ~s_q.ir[9];
      end
      GRP_FLOW:
      begin
        r = lit;
        wr_w = (s_q.ir[9:8] == SUB_0);
        jump = 1'b1;
      end
      default:
      begin
        case (s_q.ir[9:8])
          SUB_0: r = lit;
          SUB_1: r = lit | s_q.w;
          SUB_2: r = lit & s_q.w;
          default: r = lit ^ s_q.w;
        endcase
        wr_w = 1'b1;
        fm = (s_q.ir[9:8] == SUB_0) ? 3'h0 : 3'b100;
      end
    endcase
    nf[CFE_ST_Z] = (r == 8'h00);
  end

  // status after a write to it: flag bits keep their value when the instruction
  // sets flags itself, and the timeout/power-down bits are never writable
  always_comb
  begin
    st_base = s_q.st;
    if (s_q.wrf && (s_q.daddr == CFE_ADDR_STATUS))
    begin
      st_base[7:CFE_ST_HI] = s_q.res[7:CFE_ST_HI];
      st_base[2:0] = (s_q.fm != 3'h0) ? s_q.st[2:0] : s_q.res[2:0];
    end
  end

  // phase sequencer, fetch and execute
  always_comb
  begin
    s_d = s_q;
    case (s_q.ph)
      PH_ONE:
      begin
        s_d.ph = PH_TWO;
        s_d.paddr = s_q.pc[CFE_PROG_AW-1:0];
        s_d.pc = s_q.pc + 9'h001;
        s_d.daddr = faddr;
        s_d.dre = s_q.ev & rd_f & ~int_f;
      end
      PH_TWO:
      begin
        s_d.ph = PH_THREE;
        s_d.dre = 1'b0;
      end
      PH_THREE:
      begin
        s_d.ph = PH_FOUR;
        s_d.res = r;
        s_d.fl = nf;
        s_d.fm = fm;
        s_d.wrw = wr_w;
        s_d.wrf = wr_f;
        s_d.take = skip | jump | (wr_f & (faddr == CFE_ADDR_PCLOW));
        s_d.dwe = s_q.ev & wr_f & ~int_f;
      end
      default:
      begin
        s_d.ph = PH_ONE;
        s_d.dwe = 1'b0;
        s_d.ir = prog_data_i;
        s_d.ev = ~(s_q.ev & s_q.take);
        if (s_q.ev)
        begin
          if (s_q.wrw)
          begin
            s_d.w = s_q.res;
          end
          if (s_q.wrf && (s_q.daddr == CFE_ADDR_FSEL))
          begin
            s_d.fsel = s_q.res[4:0];
          end
          s_d.st = st_base;
          s_d.st[2:0] = (st_base[2:0] & ~s_q.fm) | (s_q.fl & s_q.fm);
          if (s_q.take && (grp == GRP_FLOW))
          begin
            case (s_q.ir[9:8])
              SUB_0:
              begin
                s_d.pc = s_q.stk0;
                s_d.stk0 = s_q.stk1;
              end
              SUB_1:
              begin
                s_d.pc = {1'b0, lit};
                s_d.stk0 = pc_m1;
                s_d.stk1 = s_q.stk0;
              end
              default: s_d.pc = s_q.ir[CFE_PC_W-1:0];
            endcase
          end
          else if (s_q.take && s_q.wrf && (s_q.daddr == CFE_ADDR_PCLOW))
          begin
            s_d.pc = {1'b0, s_q.res};
          end
        end
      end
    endcase
    if (mrst)
    begin
      s_d = CFE_RST_STATE;
    end
    s_d.pull = master_reset_pin_en_i | pullup_req_i;
  end

  // single state register; reset vector and phase one come from the constant
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= CFE_RST_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pullup_en_o = s_q.pull;
  assign prog_addr_o = s_q.paddr;
  assign data_addr_o = s_q.daddr;
  assign data_re_o = s_q.dre;
  assign data_we_o = s_q.dwe;
  assign data_wdata_o = s_q.res;
  assign acc_o = s_q.w;
  assign status_o = s_q.st;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i || mrst);

  sequence s_exec_phases;
    s_q.ph == PH_TWO ##1 s_q.ph == PH_THREE ##1 s_q.ph == PH_FOUR;
  endsequence

  sequence s_flushed_slot;
    !s_q.ev ##1 !data_re_o ##2 !data_we_o;
  endsequence

  a_phase_rotate: assert property (s_q.ph == PH_ONE |=> s_exec_phases ##1 s_q.ph == PH_ONE)
    else $error("phase counter left its four-step rotation");
  a_read_phase: assert property (data_re_o |-> s_q.ph == PH_TWO && !data_we_o)
    else $error("data read outside phase two");
  a_write_phase: assert property (data_we_o |-> s_q.ph == PH_FOUR && $past(s_q.ph) == PH_THREE)
    else $error("data write outside phase four");
  a_pc_increment: assert property (s_q.ph == PH_TWO |-> s_q.pc[7:0] == prog_addr_o + 8'h01)
    else $error("counter not one past the fetch address");
  a_branch_flush: assert property (s_q.ph == PH_FOUR && s_q.ev && s_q.take |=> s_flushed_slot)
    else $error("prefetched word not discarded after a branch");
  a_reset_vector: assert property ($rose(arst_n_i) |-> prog_addr_o == 8'h00 && !s_q.ev)
    else $error("fetch did not start at the reset vector");
  a_ir_capture: assert property (s_q.ph == PH_FOUR |=> s_q.ir == $past(prog_data_i))
    else $error("instruction word not captured at phase four");
  a_pullup_forced: assert property (master_reset_pin_en_i |=> pullup_en_o)
    else $error("pull-up not forced while pin is a reset");

endmodule // cfe_core

// ===== hdl/cfe_pkg.sv
package cfe_pkg;

  // widths of the core's buses
  localparam int unsigned CFE_INSN_W = 12;
  localparam int unsigned CFE_DATA_W = 8;
  localparam int unsigned CFE_PC_W = 9;
  localparam int unsigned CFE_PROG_AW = 8;
  localparam int unsigned CFE_FILE_AW = 5;

  // data-space addresses of the core's own special function registers
  localparam logic [4:0] CFE_ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] CFE_ADDR_PCLOW = 5'h02;
  localparam logic [4:0] CFE_ADDR_STATUS = 5'h03;
  localparam logic [4:0] CFE_ADDR_FSEL = 5'h04;

  // reset values, and the fixed upper bits read back from the select register
  localparam logic [8:0] CFE_PC_RST = 9'h000;
  localparam logic [7:0] CFE_STATUS_RST = 8'h18;
  localparam logic [4:0] CFE_FSEL_RST = 5'h00;
  localparam logic [2:0] CFE_FSEL_HI = 3'h7;

  // status bit positions
  localparam int unsigned CFE_ST_CARRY = 0;
  localparam int unsigned CFE_ST_Z = 2;
  localparam int unsigned CFE_ST_PD = 3;
  localparam int unsigned CFE_ST_TO = 4;
  localparam int unsigned CFE_ST_HI = 5;

  // instruction field positions
  localparam int unsigned CFE_IR_DEST = 5;
  localparam int unsigned CFE_IR_BIT_LO = 5;
  localparam int unsigned CFE_IR_NIB = 3;

  // file-register opcodes, instruction bits 11:6
  localparam logic [5:0] OP_MOVWF = 6'h00;
  localparam logic [5:0] OP_CLR = 6'h01;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_DEC = 6'h03;
  localparam logic [5:0] OP_IOR = 6'h04;
  localparam logic [5:0] OP_AND = 6'h05;
  localparam logic [5:0] OP_XOR = 6'h06;
  localparam logic [5:0] OP_ADD = 6'h07;
  localparam logic [5:0] OP_MOV = 6'h08;
  localparam logic [5:0] OP_COM = 6'h09;
  localparam logic [5:0] OP_INC = 6'h0A;
  localparam logic [5:0] OP_DECSZ = 6'h0B;
  localparam logic [5:0] OP_RR = 6'h0C;
  localparam logic [5:0] OP_RL = 6'h0D;
  localparam logic [5:0] OP_SWAP = 6'h0E;
  localparam logic [5:0] OP_INCSZ = 6'h0F;

  // instruction groups, bits 11:10, and sub-codes, bits 9:8
  localparam logic [1:0] GRP_FILE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_FLOW = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  localparam logic [1:0] SUB_0 = 2'h0;
  localparam logic [1:0] SUB_1 = 2'h1;
  localparam logic [1:0] SUB_2 = 2'h2;

  // phase counter, gray coded along its rotation
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR = 2'b10
  } cfe_phase_t;

  // whole state of the core
  typedef struct packed {
    cfe_phase_t ph;
    logic [8:0] pc;
    logic [7:0] paddr;
    logic [11:0] ir;
    logic ev;
    logic [7:0] w;
    logic [7:0] st;
    logic [4:0] fsel;
    logic [8:0] stk0;
    logic [8:0] stk1;
    logic [7:0] res;
    logic [2:0] fl;
    logic [2:0] fm;
    logic wrw;
    logic wrf;
    logic take;
    logic [4:0] daddr;
    logic dre;
    logic dwe;
    logic pull;
  } cfe_state_t;

  localparam cfe_state_t CFE_RST_STATE = '{ph: PH_ONE, pc: CFE_PC_RST, st: CFE_STATUS_RST,
    fsel: CFE_FSEL_RST, pull: 1'b1, default: '0};

endpackage

// ===== testbench/cfe_mem_model.sv
`timescale 1ns/100ps
module cfe_mem_model
  import cfe_pkg::*;
(
  input wire logic mclk_i,                          // core clock
  input wire logic clr_i,                           // clears the access counts
  input wire logic [CFE_PROG_AW-1:0] prog_addr_i,   // flash address
  output logic [CFE_INSN_W-1:0] prog_data_o,        // flash word
  input wire logic [CFE_FILE_AW-1:0] data_addr_i,   // file address
  input wire logic data_re_i,                       // read strobe
  input wire logic data_we_i,                       // write strobe
  input wire logic [CFE_DATA_W-1:0] data_wdata_i,   // write data
  output logic [CFE_DATA_W-1:0] data_rdata_o,       // read data
  output int num_rd_o,                              // reads seen
  output int num_wr_o,                              // writes seen
  output logic [CFE_DATA_W-1:0] file_o              // byte held at file 10h
);
  logic [CFE_INSN_W-1:0] rom [0:255];
  logic [CFE_DATA_W-1:0] ram [0:31];
  // test program; 00FFh keeps its calibration word and is never written
  initial
  begin
    foreach (rom[i]) rom[i] = 12'h000;
    foreach (ram[i]) ram[i] = 8'h00;
    rom[0] = 12'hC0F;
    rom[1] = 12'h030;
    rom[2] = 12'hC01;
    rom[3] = 12'h1F0;
    rom[4] = 12'hCF0;
    rom[5] = 12'h1D0;
    rom[6] = 12'h090;
    rom[7] = 12'hAFE;
    rom[254] = 12'h063;
    rom[255] = 12'hCA5;
    data_rdata_o = 8'h5A;
  end
  // flash answers at once, read only
  assign prog_data_o = rom[prog_addr_i];
  assign file_o = ram[16];
  // read data stands one cycle only; it scrambles otherwise to expose late sampling
  always @(posedge mclk_i)
  begin
    if (data_re_i)
      data_rdata_o <= ram[data_addr_i];
    else
      data_rdata_o <= ~data_rdata_o;
    if (data_we_i)
      ram[data_addr_i] <= data_wdata_i;
    num_rd_o <= clr_i ? 0 : num_rd_o + int'(data_re_i);
    num_wr_o <= clr_i ? 0 : num_wr_o + int'(data_we_i);
  end
endmodule // cfe_mem_model

// ===== testbench/tb_cfe_core.sv
`timescale 1ns/100ps
module tb_cfe_core
  import cfe_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] acc;
    logic [7:0] st;
  } cfe_row_t;
  logic mclk_i, arst_n_i, mrst_en, mrst_pin_n, pull_req, clr;
  logic pullup_en_o, data_re_o, data_we_o;
  logic [7:0] prog_addr_o, acc_o, status_o, data_wdata_o, data_rdata, file_b, last_addr;
  logic [11:0] prog_data;
  logic [4:0] data_addr_o;
  int num_rd, num_wr, num_errors, num_checks;
  cfe_row_t rows [0:11];
  cfe_core cfe_core_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .master_reset_pin_en_i(mrst_en),
    .master_reset_pin_n_i(mrst_pin_n), .pullup_req_i(pull_req), .pullup_en_o(pullup_en_o),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data), .data_addr_o(data_addr_o),
    .data_re_o(data_re_o), .data_rdata_i(data_rdata), .data_we_o(data_we_o),
    .data_wdata_o(data_wdata_o), .acc_o(acc_o), .status_o(status_o));
  cfe_mem_model cfe_mem_model_inst (.mclk_i(mclk_i), .clr_i(clr), .prog_addr_i(prog_addr_o),
    .prog_data_o(prog_data), .data_addr_i(data_addr_o), .data_re_i(data_re_o),
    .data_we_i(data_we_o), .data_wdata_i(data_wdata_o), .data_rdata_o(data_rdata),
    .num_rd_o(num_rd), .num_wr_o(num_wr), .file_o(file_b));
  // 200 MHz core clock
  always #2.5 mclk_i = ~mclk_i;
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for the next fetch address, counting cycles between them
  task automatic wait_addr(output int gap);
    gap = 0;
    while (prog_addr_o === last_addr && gap < 40)
    begin
      @(negedge mclk_i);
      gap++;
    end
    if (gap >= 40)
    begin
      num_errors++;
      report_and_stop();
    end
    last_addr = prog_addr_o;
  endtask
  // each row: new fetch address, state left by the word fetched two slots earlier
  task automatic run_rows();
    int gap;
    last_addr = 8'h00;
    for (int i = 0; i < 12; i++)
    begin
      wait_addr(gap);
      check(prog_addr_o, rows[i].addr);
      check(acc_o, rows[i].acc);
      check(status_o, rows[i].st);
      if (i > 0)
        check(gap[7:0], 8'h04);
    end
    check(num_rd[7:0], 8'h03);
    check(num_wr[7:0], 8'h02);
    check(file_b, 8'h10);
  endtask
  initial
  begin
    rows = '{'{8'h01, 8'h00, 8'h18},
      '{8'h02, 8'h0F, 8'h18},
      '{8'h03, 8'h0F, 8'h18},
      '{8'h04, 8'h01, 8'h18},
      '{8'h05, 8'h01, 8'h1A},
      '{8'h06, 8'hF0, 8'h1A},
      '{8'h07, 8'h00, 8'h1D},
      '{8'h08, 8'h10, 8'h1B},
      '{8'hFE, 8'h10, 8'h1B},
      '{8'hFF, 8'h10, 8'h1B},
      '{8'h00, 8'h10, 8'h1F},
      '{8'h01, 8'hA5, 8'h1F}};
    mclk_i = 1'b0;
    arst_n_i = 1'b0;
    mrst_en = 1'b0;
    mrst_pin_n = 1'b1;
    pull_req = 1'b0;
    clr = 1'b1;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk_i);
    check(prog_addr_o, 8'h00);
    check(status_o, CFE_STATUS_RST);
    check(acc_o, 8'h00);
    arst_n_i <= 1'b1;
    clr <= 1'b0;
    run_rows();
    // pull-up follows software while the pin is a plain input
    @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    #1;
    check({7'h00, pullup_en_o}, 8'h00);
    @(posedge mclk_i);
    pull_req <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    check({7'h00, pullup_en_o}, 8'h01);
    // pin as reset, held low: core restarts and the pull-up is forced
    @(posedge mclk_i);
    pull_req <= 1'b0;
    mrst_en <= 1'b1;
    mrst_pin_n <= 1'b0;
    clr <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    check({7'h00, pullup_en_o}, 8'h01);
    check(prog_addr_o, 8'h00);
    check(acc_o, 8'h00);
    check(status_o, CFE_STATUS_RST);
    @(posedge mclk_i);
    mrst_pin_n <= 1'b1;
    clr <= 1'b0;
    run_rows();
    report_and_stop();
  end
endmodule // tb_cfe_core
